// [rtl/bdv_bus_monitor.sv]
`timescale 1ns/1ps
module bdv_bus_monitor
  import bdv_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       cycle_start_i,
  input  wire logic       cycle_active_i,
  input  wire logic       cycle_external_i,
  input  wire logic       transfer_ack_i,
  input  wire logic       debug_mode_i,
  input  wire logic [1:0] timeout_select_i,
  input  wire logic       external_enable_i,
  input  wire logic       debug_disable_i,
  output logic            timeout_o
);

  logic [6:0] count_reg;
  logic       watch;

  assign watch = (!cycle_external_i || external_enable_i)
                 && !(debug_disable_i && debug_mode_i);

  // Each external half of a split access arrives as its own start.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      count_reg <= BDV_CNT_ZERO;
    end else if (cycle_start_i) begin
      count_reg <= BDV_CNT_ONE;
    end else if (cycle_active_i && watch && !transfer_ack_i
                 && count_reg != bdv_limit(timeout_select_i)) begin
      count_reg <= count_reg + BDV_CNT_ONE;
    end else if (!cycle_active_i) begin
      count_reg <= BDV_CNT_ZERO;
    end
  end

  // Single pulse when the count stands one below the limit, whether or not acknowledge arrives.
  assign timeout_o = cycle_active_i && watch && !cycle_start_i
                     && count_reg == bdv_limit(timeout_select_i)
                     - BDV_CNT_ONE;

  limit_bound_a: assert property (@(posedge clk_i)
    disable iff (rst_i) count_reg <= BDV_LIMIT_64)
    else $error("monitor count over range");

  debug_mute_a: assert property (@(posedge clk_i)
    disable iff (rst_i) (debug_disable_i && debug_mode_i) |-> !timeout_o)
    else $error("timeout raised in debug mode");

endmodule

// [rtl/bdv_debug_visibility.sv]
`timescale 1ns/1ps
module bdv_debug_visibility
  import bdv_pkg::*;
(
  input  wire logic           clk_i,
  input  wire logic           rst_i,
  input  bdv_config_type      config_i,
  input  wire logic           cycle_start_i,
  input  bdv_cycle_type       cycle_i,
  input  wire logic           cycle_external_i,
  input  wire logic           ack_i,
  input  wire logic           error_ack_i,
  input  wire logic [31:0]    read_data_i,
  input  wire logic [31:0]    write_data_i,
  input  wire logic [3:0]     status_i,
  input  wire logic           gpio_out_i,
  input  wire logic           gpio_oe_i,
  input  wire logic           strobe_pin_i,
  output logic                gpio_in_o,
  output logic                show_strobe_n_o,
  output logic                show_strobe_oe_o,
  output logic [2:0]          transfer_code_o,
  output logic [2:0]          transfer_code_oe_o,
  output logic [1:0]          transfer_size_o,
  output logic                write_o,
  output logic [1:0]          emulation_chip_select_o,
  output logic [3:0]          processor_status_bits_o,
  output logic                status_pins_oe_o,
  output logic [31:0]         data_o,
  output logic                data_oe_o,
  output logic                output_enable_n_o,
  output logic [3:0]          byte_enable_n_o,
  output logic                cycle_done_o,
  output logic                cycle_error_o
);

  typedef enum logic [2:0] {
    BDV_IDLE = 3'b001,
    BDV_WAIT = 3'b010,
    BDV_DATA = 3'b100
  } bdv_state_type;

  bdv_state_type state_reg;
  bdv_state_type state_next;
  bdv_cycle_type attr_reg;
  logic          ext_reg;
  logic          show_reg;
  logic          strobe_n_reg;
  logic [31:0]   data_reg;
  logic          data_oe_reg;
  logic          timeout;
  logic          active;
  logic          terminate;
  logic          show_en;
  logic          emu_pins;

  function automatic logic [2:0] tc_encode(input bdv_cycle_type c);
    logic [2:0] code;
    code = BDV_TC_USER_DATA;
    unique case (c.kind)
      BDV_ACC_VECT: code = BDV_TC_SUPV_VECT;
      BDV_ACC_INSN: code = c.cof ? BDV_TC_USER_COF : BDV_TC_USER_INSN;
      BDV_ACC_DATA: code = c.literal_load ? BDV_TC_USER_INSN
                                          : BDV_TC_USER_DATA;
      default:      code = BDV_TC_USER_DATA;
    endcase
    // The supervisor flag only ever adds the top bit.
    if (c.supervisor || c.kind == BDV_ACC_VECT) begin
      code[BDV_TC_SUPV_BIT] = 1'b1;
    end
    tc_encode = code;
  endfunction

  assign active   = state_reg == BDV_WAIT;
  assign show_en  = config_i.emulation_mode
                    || config_i.show_cycle_enable;
  assign emu_pins = config_i.emulation_mode;

  bdv_bus_monitor u_monitor (
    .clk_i             (clk_i),
    .rst_i             (rst_i),
    .cycle_start_i     (cycle_start_i),
    .cycle_active_i    (active),
    .cycle_external_i  (ext_reg),
    .transfer_ack_i    (ack_i),
    .debug_mode_i      (status_i == BDV_PST_DEBUG),
    .timeout_select_i  (config_i.monitor_timeout_select),
    .external_enable_i (config_i.monitor_external_enable),
    .debug_disable_i   (config_i.monitor_debug_disable),
    .timeout_o         (timeout)
  );

  assign terminate = active && (ack_i || error_ack_i || timeout);

  // Error wins over acknowledge; the monitor never raises an interrupt.
  assign cycle_done_o  = terminate && !(error_ack_i || timeout);
  assign cycle_error_o = active && (error_ack_i || timeout);

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      BDV_IDLE: if (cycle_start_i) state_next = BDV_WAIT;
      BDV_WAIT: if (terminate) state_next = BDV_DATA;
      BDV_DATA: state_next = cycle_start_i ? BDV_WAIT : BDV_IDLE;
      default:  state_next = BDV_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= BDV_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      attr_reg <= '0;
      ext_reg  <= 1'b0;
      show_reg <= 1'b0;
    end else if (cycle_start_i) begin
      attr_reg <= cycle_i;
      ext_reg  <= cycle_external_i;
      show_reg <= !cycle_external_i && show_en;
    end
  end

  // Low for the whole external or shown cycle, high once data stands: one pulse per such cycle.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      strobe_n_reg <= 1'b1;
    end else if (cycle_start_i && (cycle_external_i || show_en)) begin
      strobe_n_reg <= 1'b0;
    end else if (terminate) begin
      strobe_n_reg <= 1'b1;
    end
  end

  // Show data appears the clock after the internal cycle ends. It is
  // released after that one clock so a following read never meets it.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      data_reg    <= '0;
      data_oe_reg <= 1'b0;
    end else if (terminate && (show_reg || ext_reg)) begin
      data_reg    <= attr_reg.write ? write_data_i : read_data_i;
      data_oe_reg <= show_reg || attr_reg.write;
    end else if (state_reg == BDV_DATA) begin
      data_oe_reg <= 1'b0;
    end
  end

  assign show_strobe_n_o  = config_i.strobe_as_gpio && !emu_pins
                            ? gpio_out_i : strobe_n_reg;
  assign show_strobe_oe_o = config_i.strobe_as_gpio && !emu_pins
                            ? gpio_oe_i : 1'b1;
  assign gpio_in_o        = strobe_pin_i;

  assign transfer_code_o    = tc_encode(attr_reg);
  assign transfer_code_oe_o = emu_pins ? 3'h7
                              : config_i.transfer_code_pin_assign;
  assign transfer_size_o    = attr_reg.size;
  assign write_o            = attr_reg.write;
  assign emulation_chip_select_o = ext_reg ? BDV_CSE_EXTERNAL
                                   : attr_reg.chip_select;

  // Status codes pass straight from the core as already encoded.
  assign processor_status_bits_o = status_i;
  assign status_pins_oe_o = emu_pins || config_i.status_pins_enable;

  assign data_o            = data_reg;
  assign data_oe_o         = data_oe_reg;
  assign output_enable_n_o = !(active && ext_reg && !attr_reg.write);
  assign byte_enable_n_o   = (active && ext_reg) ? 4'h0 : 4'hF;

  // Steps of a cycle, shared by the properties below.
  sequence shown_start_s;
    cycle_start_i && (cycle_external_i || show_en);
  endsequence

  sequence plain_end_s;
    terminate && !cycle_start_i;
  endsequence

  sequence watched_start_s;
    cycle_start_i && !active
      && (!cycle_external_i || config_i.monitor_external_enable)
      && !config_i.monitor_debug_disable
      && bdv_limit(config_i.monitor_timeout_select) == BDV_LIMIT_8;
  endsequence

  sequence silent_wait_s;
    active && !ack_i && !error_ack_i;
  endsequence

  one_pulse_a: assert property (@(posedge clk_i)
    disable iff (rst_i) $fell(strobe_n_reg) |-> $past(cycle_start_i))
    else $error("strobe fell without a new cycle");

  strobe_low_a: assert property (@(posedge clk_i)
    disable iff (rst_i) shown_start_s |=> !strobe_n_reg)
    else $error("strobe not low after start");

  strobe_high_a: assert property (@(posedge clk_i)
    disable iff (rst_i) plain_end_s |=> strobe_n_reg)
    else $error("strobe not high after end");

  strobe_held_a: assert property (@(posedge clk_i)
    disable iff (rst_i)
    (active && !terminate && !strobe_n_reg) |=> !strobe_n_reg)
    else $error("strobe rose inside a cycle");

  hidden_cycle_a: assert property (@(posedge clk_i)
    disable iff (rst_i)
    (cycle_start_i && !cycle_external_i && !show_en && strobe_n_reg)
      |=> strobe_n_reg)
    else $error("strobe pulsed for hidden cycle");

  show_enables_a: assert property (@(posedge clk_i)
    disable iff (rst_i)
    (active && show_reg) |-> output_enable_n_o && byte_enable_n_o == 4'hF)
    else $error("enables asserted in show cycle");

  idle_enables_a: assert property (@(posedge clk_i)
    disable iff (rst_i)
    !active |-> output_enable_n_o && byte_enable_n_o == 4'hF)
    else $error("enables asserted outside a cycle");

  error_wins_a: assert property (@(posedge clk_i)
    disable iff (rst_i)
    (active && timeout && ack_i) |-> cycle_error_o && !cycle_done_o)
    else $error("ack beat timeout");

  error_once_a: assert property (@(posedge clk_i)
    disable iff (rst_i) cycle_error_o |=> !active && !cycle_error_o)
    else $error("error did not end the cycle");

  done_once_a: assert property (@(posedge clk_i)
    disable iff (rst_i) cycle_done_o |=> !active && !cycle_done_o)
    else $error("done did not end the cycle");

  timeout_pulse_a: assert property (@(posedge clk_i)
    disable iff (rst_i) timeout |=> !timeout)
    else $error("timeout longer than one cycle");

  limit_eight_a: assert property (@(posedge clk_i)
    disable iff (rst_i)
    watched_start_s ##1 silent_wait_s [*6] |=> timeout && cycle_error_o)
    else $error("monitor missed the short limit");

  unwatched_ext_a: assert property (@(posedge clk_i)
    disable iff (rst_i)
    (active && ext_reg && !config_i.monitor_external_enable) |-> !timeout)
    else $error("external cycle timed while unwatched");

  strobe_rest_a: assert property (@(posedge clk_i)
    disable iff (rst_i)
    (state_reg == BDV_IDLE && !cycle_start_i) |=> strobe_n_reg
      || cycle_start_i)
    else $error("strobe low while idle");

  data_strobe_a: assert property (@(posedge clk_i)
    disable iff (rst_i) state_reg == BDV_DATA |-> strobe_n_reg)
    else $error("strobe low while data stands");

  tc_super_a: assert property (@(posedge clk_i)
    disable iff (rst_i)
    attr_reg.supervisor |-> transfer_code_o[BDV_TC_SUPV_BIT])
    else $error("supervisor bit missing");

  tc_user_a: assert property (@(posedge clk_i)
    disable iff (rst_i)
    (!attr_reg.supervisor && attr_reg.kind != BDV_ACC_VECT)
      |-> !transfer_code_o[BDV_TC_SUPV_BIT])
    else $error("user cycle marked supervisor");

  tc_vector_a: assert property (@(posedge clk_i)
    disable iff (rst_i)
    attr_reg.kind == BDV_ACC_VECT |-> transfer_code_o == BDV_TC_SUPV_VECT)
    else $error("vector fetch miscoded");

  tc_reserved_a: assert property (@(posedge clk_i)
    disable iff (rst_i) transfer_code_o != BDV_TC_RESERVED)
    else $error("reserved transfer code shown");

  literal_insn_a: assert property (@(posedge clk_i)
    disable iff (rst_i)
    (attr_reg.kind == BDV_ACC_DATA && attr_reg.literal_load)
      |-> transfer_code_o[1:0] == BDV_TC_USER_INSN[1:0])
    else $error("literal load not shown as instruction");

  ext_select_a: assert property (@(posedge clk_i)
    disable iff (rst_i)
    (cycle_start_i && cycle_external_i)
      |=> emulation_chip_select_o == BDV_CSE_EXTERNAL)
    else $error("external cycle not shown as external");

  attr_stable_a: assert property (@(posedge clk_i)
    disable iff (rst_i)
    (active && !cycle_start_i) |=> $stable(transfer_code_o)
      && $stable(transfer_size_o) && $stable(write_o))
    else $error("cycle attributes moved mid cycle");

  pst_enable_a: assert property (@(posedge clk_i)
    disable iff (rst_i)
    config_i.emulation_mode
      |-> status_pins_oe_o && transfer_code_oe_o == 3'h7)
    else $error("emulation pins not driven");

  pins_idle_a: assert property (@(posedge clk_i)
    disable iff (rst_i)
    (!config_i.emulation_mode && !config_i.status_pins_enable)
      |-> !status_pins_oe_o)
    else $error("status pins driven while disabled");

  show_data_a: assert property (@(posedge clk_i)
    disable iff (rst_i) (terminate && show_reg) |=> data_oe_o)
    else $error("show data late");

  show_read_a: assert property (@(posedge clk_i)
    disable iff (rst_i)
    (terminate && show_reg && !attr_reg.write)
      |=> data_o == $past(read_data_i))
    else $error("show data does not match the read");

  data_release_a: assert property (@(posedge clk_i)
    disable iff (rst_i) state_reg == BDV_DATA |=> !data_oe_o)
    else $error("data still driven after its clock");

endmodule

// [rtl/bdv_pkg.sv]
package bdv_pkg;

  // Transfer codes.
  localparam logic [2:0] BDV_TC_USER_DATA  = 3'h0;
  localparam logic [2:0] BDV_TC_RESERVED   = 3'h1;
  localparam logic [2:0] BDV_TC_USER_INSN  = 3'h2;
  localparam logic [2:0] BDV_TC_USER_COF   = 3'h3;
  localparam logic [2:0] BDV_TC_SUPV_DATA  = 3'h4;
  localparam logic [2:0] BDV_TC_SUPV_VECT  = 3'h5;
  localparam logic [2:0] BDV_TC_SUPV_INSN  = 3'h6;
  localparam logic [2:0] BDV_TC_SUPV_COF   = 3'h7;
  localparam int         BDV_TC_SUPV_BIT   = 2;

  // Processor status codes.
  localparam logic [3:0] BDV_PST_STALL0    = 4'h0;
  localparam logic [3:0] BDV_PST_STALL1    = 4'h1;
  localparam logic [3:0] BDV_PST_EXCEPT    = 4'h2;
  localparam logic [3:0] BDV_PST_RSVD3     = 4'h3;
  localparam logic [3:0] BDV_PST_LOWPWR    = 4'h4;
  localparam logic [3:0] BDV_PST_STALL5    = 4'h5;
  localparam logic [3:0] BDV_PST_DEBUG     = 4'h6;
  localparam logic [3:0] BDV_PST_RSVD7     = 4'h7;
  localparam logic [3:0] BDV_PST_LAUNCH    = 4'h8;
  localparam logic [3:0] BDV_PST_MULTI     = 4'h9;
  localparam logic [3:0] BDV_PST_ACCEL     = 4'hA;
  localparam logic [3:0] BDV_PST_LITERAL   = 4'hB;
  localparam logic [3:0] BDV_PST_COF       = 4'hC;
  localparam logic [3:0] BDV_PST_RTE       = 4'hD;
  localparam logic [3:0] BDV_PST_RSVDE     = 4'hE;
  localparam logic [3:0] BDV_PST_INDIRECT  = 4'hF;

  // Emulation chip select codes.
  localparam logic [1:0] BDV_CSE_MODREG    = 2'h3;
  localparam logic [1:0] BDV_CSE_PORTREG   = 2'h2;
  localparam logic [1:0] BDV_CSE_INTERNAL  = 2'h1;
  localparam logic [1:0] BDV_CSE_EXTERNAL  = 2'h0;

  // Bus monitor limits in system clocks, selected by a two-bit field.
  localparam logic [6:0] BDV_LIMIT_8       = 7'h08;
  localparam logic [6:0] BDV_LIMIT_16      = 7'h10;
  localparam logic [6:0] BDV_LIMIT_32      = 7'h20;
  localparam logic [6:0] BDV_LIMIT_64      = 7'h40;
  localparam logic [6:0] BDV_CNT_ONE       = 7'h01;
  localparam logic [6:0] BDV_CNT_ZERO      = 7'h00;

  // Kind of access presented by the core.
  typedef enum logic [1:0] {
    BDV_ACC_INSN = 2'h0,
    BDV_ACC_DATA = 2'h1,
    BDV_ACC_VECT = 2'h2
  } bdv_access_type;

  // Cycle attributes that travel together.
  typedef struct packed {
    logic           supervisor;
    bdv_access_type kind;
    logic           cof;
    logic           literal_load;
    logic [1:0]     size;
    logic           write;
    logic [1:0]     chip_select;
  } bdv_cycle_type;

  // Configuration bits.
  typedef struct packed {
    logic       emulation_mode;
    logic       show_cycle_enable;
    logic       strobe_as_gpio;
    logic       status_pins_enable;
    logic [2:0] transfer_code_pin_assign;
    logic [1:0] monitor_timeout_select;
    logic       monitor_external_enable;
    logic       monitor_debug_disable;
  } bdv_config_type;

  function automatic logic [6:0] bdv_limit(input logic [1:0] sel);
    unique case (sel)
      2'h0:    bdv_limit = BDV_LIMIT_8;
      2'h1:    bdv_limit = BDV_LIMIT_16;
      2'h2:    bdv_limit = BDV_LIMIT_32;
      default: bdv_limit = BDV_LIMIT_64;
    endcase
  endfunction

endpackage

// [tb/bdv_observer.sv]
`timescale 1ns/1ps
// Stands in for the emulator that latches pin state while the strobe is low and counts its pulses.
module bdv_observer
  import bdv_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       strobe_n_i,
  input  wire logic [2:0] code_i,
  output int              pulses_o,
  output logic [2:0]      code_o
);
  logic last_reg;
  always_ff @(posedge clk_i) begin
    last_reg <= rst_i | strobe_n_i;
    if (rst_i) begin
      pulses_o <= 0;
    end else if (!last_reg && strobe_n_i) begin
      pulses_o <= pulses_o + 1;
    end
    if (!strobe_n_i) begin
      code_o <= code_i;
    end
  end
endmodule

// [tb/tb_bus_debug_visibility_monitor.sv]
`timescale 1ns/1ps
module tb_bus_debug_visibility_monitor;
  import bdv_pkg::*;
  logic clk_i, rst_i, start, ext, ack, eack, gout, goe, got_err;
  logic gin, shs_n, shs_oe, wr, pst_oe, dat_oe, oe_n, done, err;
  logic [2:0] tc, tc_oe, tc_seen;
  logic [1:0] tsz, cse, cse_seen;
  logic [3:0] st, pst, be_n;
  logic [31:0] rd, wd, dat;
  bdv_config_type cfg;
  bdv_cycle_type cyc, c;
  wire pin = shs_oe ? shs_n : 1'b1;
  int fail_count, total_checks, n, p0, i, j;
  logic [2:0] lc;
  bdv_debug_visibility dut_u (.clk_i(clk_i), .rst_i(rst_i), .config_i(cfg),
    .cycle_start_i(start), .cycle_i(cyc), .cycle_external_i(ext),
    .ack_i(ack), .error_ack_i(eack), .read_data_i(rd), .write_data_i(wd),
    .status_i(st), .gpio_out_i(gout), .gpio_oe_i(goe),
    .strobe_pin_i(pin), .gpio_in_o(gin), .show_strobe_n_o(shs_n),
    .show_strobe_oe_o(shs_oe), .transfer_code_o(tc),
    .transfer_code_oe_o(tc_oe), .transfer_size_o(tsz), .write_o(wr),
    .emulation_chip_select_o(cse), .processor_status_bits_o(pst),
    .status_pins_oe_o(pst_oe), .data_o(dat), .data_oe_o(dat_oe),
    .output_enable_n_o(oe_n), .byte_enable_n_o(be_n),
    .cycle_done_o(done), .cycle_error_o(err));
  bdv_observer obs_u (.clk_i(clk_i), .rst_i(rst_i), .strobe_n_i(pin),
    .code_i(tc), .pulses_o(p0), .code_o(lc));
  initial begin
    clk_i = 0;
    forever #50 clk_i = ~clk_i;
  end
  task check(input logic [63:0] s, input logic [63:0] e);
    total_checks++;
    if (s !== e) begin
      fail_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task wrap_up;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // Issues one cycle, acks on wait cycle lat (0 never); n is its length.
  task run(input bdv_cycle_type cc, input logic x, input int lat);
    @(posedge clk_i);
    start <= 1;
    cyc <= cc;
    ext <= x;
    @(posedge clk_i);
    start <= 0;
    n = 0;
    while (n < 80) begin
      n++;
      if (n == lat) ack <= 1;
      @(negedge clk_i);
      if (n == 1) begin
        tc_seen = tc;
        cse_seen = cse;
      end
      got_err = (err === 1'b1);
      if (got_err || done === 1'b1) break;
      @(posedge clk_i);
    end
    @(posedge clk_i);
    ack <= 0;
    @(negedge clk_i);
  endtask
  initial begin
    repeat (20000) @(posedge clk_i);
    fail_count++;
    wrap_up;
  end
  initial begin
    {start, ext, ack, eack, gout, goe} = '0;
    cfg = '0;
    cfg.emulation_mode = 1;
    cfg.monitor_external_enable = 1;
    cyc = '0;
    rd = 32'h0;
    wd = 32'hC3C3_5A5A;
    st = 4'h8;
    rst_i = 1;
    repeat (12) @(posedge clk_i);
    rst_i <= 0;
    @(negedge clk_i);
    check(shs_n, 1);
    check(shs_oe, 1);
    check(dat_oe, 0);
    check(tc_oe, 3'h7);
    for (i = 0; i < 16; i++) begin
      @(posedge clk_i) st <= i;
      @(negedge clk_i) check({pst_oe, pst}, {1'b1, i[3:0]});
    end
    st <= 4'h8;
    j = p0;
    for (i = 0; i < 10; i++) begin
      c = '0;
      c.supervisor = i[0] | (i > 7);
      c.kind = (i < 2 || i > 5) ? BDV_ACC_DATA : BDV_ACC_INSN;
      if (i > 7) c.kind = BDV_ACC_VECT;
      c.cof = (i == 4 || i == 5);
      c.literal_load = (i == 6 || i == 7);
      c.write = i[1];
      c.size = i[2:1];
      c.chip_select = i[1:0];
      rd <= 32'hA5A5_0000 | i;
      run(c, 0, 1);
      check(n, 1);
      check(tc_seen, {c.supervisor, i > 7 ? 2'h1 : i < 2 ? 2'h0
                      : i < 4 || i > 5 ? 2'h2 : 2'h3});
      check(cse_seen, i[1:0]);
      check({tsz, wr}, {c.size, c.write});
      check({dat_oe, oe_n, be_n}, 6'h3F);
      check(dat, c.write ? wd : 32'hA5A5_0000 | i);
    end
    repeat (2) @(negedge clk_i);
    check(p0 - j, 10);
    check(lc, 3'h5);
    c = '0;
    for (i = 0; i < 4; i++) begin
      @(posedge clk_i) cfg.monitor_timeout_select <= i;
      run(c, 1, 0);
      check(n, (8 << i) - 1);
      check({got_err, err}, 2'h2);
    end
    @(posedge clk_i) cfg.monitor_timeout_select <= 0;
    run(c, 0, 7);
    check({got_err, n}, {1'b1, 32'd7});
    @(posedge clk_i) cfg.monitor_external_enable <= 0;
    run(c, 1, 20);
    check({got_err, n}, {1'b0, 32'd20});
    @(posedge clk_i) cfg.monitor_debug_disable <= 1;
    st <= 4'h6;
    run(c, 0, 20);
    check({got_err, n}, {1'b0, 32'd20});
    @(posedge clk_i) cfg <= '{transfer_code_pin_assign: 3'h5, default: '0};
    st <= 4'h8;
    @(negedge clk_i) j = p0;
    run(c, 0, 1);
    check({dat_oe, tc_oe, pst_oe}, 5'h0A);
    repeat (2) @(negedge clk_i);
    check(p0, j);
    @(posedge clk_i) cfg.strobe_as_gpio <= 1;
    goe <= 1;
    for (i = 0; i < 2; i++) begin
      @(posedge clk_i) gout <= i;
      @(negedge clk_i) check({shs_n, gin}, {2{i[0]}});
    end
    wrap_up;
  end
endmodule
